//--- core/scc_top.sv
// System clock control: source select, crystal control, watchdog, resets and wake timing.
`timescale 1ns/100ps
module scc_top #(
	parameter logic [18:0] WDT_LIM0 = scc_pkg::WDT_PER0,
	parameter logic [18:0] WDT_LIM1 = scc_pkg::WDT_PER1,
	parameter logic [18:0] WDT_LIM2 = scc_pkg::WDT_PER2,
	parameter logic [18:0] WDT_LIM3 = scc_pkg::WDT_PER3
) (
	input wire logic clock,
	input wire logic rstn,
	input wire scc_pkg::scc_apb_req_t apb_req,
	output scc_pkg::scc_apb_rsp_t apb_rsp,
	input wire logic low_rate_tick,
	input wire logic xtal_stable,
	input wire logic boot_fast_cfg,
	input wire logic port_a_bit5_is_input,
	input wire logic ext_reset_in_n,
	input wire logic lvr_low_v,
	input wire logic stop_light_req,
	input wire logic stop_deep_req,
	input wire logic wake_evt,
	output logic cpu_run_q,
	output logic cpu_hang_q,
	output logic sys_reset_q,
	output logic lvr_reset_q,
	output logic ext_reset_q,
	output logic [1:0] clk_src_q,
	output logic [2:0] clk_div_code_q,
	output logic low_rate_en_q,
	output logic xtal_en_q,
	output logic [1:0] xtal_drive_q,
	output logic xtal_pad_analog_q
);
	scc_pkg::scc_regs_t q;
	scc_pkg::scc_regs_t d;

	logic [7:0] a;
	logic [7:0] w;
	logic acc;
	logic done;
	logic wr;
	logic wr_cmr;
	logic wdt_clr;
	logic wdt_en;
	logic wdt_hit;
	logic wdt_done;
	logic [18:0] wdt_cnt;
	logic [18:0] wdt_lim;
	logic dly_clr;
	logic dly_done;
	logic [11:0] dly_lim;
	logic [7:0] stat;
	logic [1:0] nsrc;

	function automatic logic [1:0] src_of(input logic [7:0] m);
		if (m[scc_pkg::CMR_HRC_BIT])
			src_of = scc_pkg::SRC_HIGH;
		else if (m[scc_pkg::CMR_DIV_MSB:scc_pkg::CMR_DIV_LSB] == scc_pkg::CMR_XTAL_CODE)
			src_of = scc_pkg::SRC_XTAL;
		else
			src_of = scc_pkg::SRC_LOW;
	endfunction : src_of

	// The high-rate oscillator has no stop bit here, so it always counts as running.
	function automatic logic osc_on(input logic [1:0] s, input logic lrc, input logic xen);
		case (s)
			scc_pkg::SRC_LOW: osc_on = lrc;
			scc_pkg::SRC_HIGH: osc_on = 1'b1;
			scc_pkg::SRC_XTAL: osc_on = xen;
			default: osc_on = 1'b0;
		endcase
	endfunction : osc_on

	assign a = apb_req.paddr;
	assign w = apb_req.pwdata[7:0];
	assign acc = apb_req.psel && apb_req.penable && !q.rsp.pready;
	assign done = apb_req.psel && apb_req.penable && q.rsp.pready;
	assign wr = done && apb_req.pwrite && !q.rsp.pslverr;
	assign wr_cmr = wr && (a == scc_pkg::OFS_CLK_MODE);
	assign nsrc = src_of(w);

	assign wdt_en = q.cmr[scc_pkg::CMR_WDT_EN_BIT];
	assign wdt_clr = !wdt_en || q.sys_rst || (wr && (a == scc_pkg::OFS_WDT_CLEAR));
	assign wdt_hit = wdt_done && wdt_en && !q.sys_rst;

	always_comb
	begin
		case (q.aux[scc_pkg::AUX_WDT_PER_MSB:scc_pkg::AUX_WDT_PER_LSB])
			2'h0: wdt_lim = WDT_LIM0;
			2'h1: wdt_lim = WDT_LIM1;
			2'h2: wdt_lim = WDT_LIM2;
			2'h3: wdt_lim = WDT_LIM3;
			default: wdt_lim = WDT_LIM0;
		endcase
	end

	// The watchdog only sees low-rate ticks, so it freezes while that oscillator is off.
	scc_tick_counter #(
		.W(scc_pkg::WDT_W)
	) u_wdt (
		.clock(clock),
		.rstn(rstn),
		.clr(wdt_clr),
		.inc(low_rate_tick && q.cmr[scc_pkg::CMR_LRC_EN_BIT]),
		.limit(wdt_lim),
		.cnt(wdt_cnt),
		.done(wdt_done)
	);

	assign dly_clr = !((q.state == scc_pkg::SCC_BOOT && q.cap_done) || q.state == scc_pkg::SCC_WAKE);

	always_comb
	begin
		if (q.state == scc_pkg::SCC_BOOT)
			dly_lim = q.boot_fast ? scc_pkg::DLY_FAST : scc_pkg::DLY_SLOW;
		else
			dly_lim = q.aux[scc_pkg::AUX_FAST_WAKE_BIT] ? scc_pkg::DLY_FAST : scc_pkg::DLY_SLOW;
	end

	scc_tick_counter #(
		.W(scc_pkg::DLY_W)
	) u_dly (
		.clock(clock),
		.rstn(rstn),
		.clr(dly_clr),
		.inc(low_rate_tick),
		.limit(dly_lim),
		.cnt(),
		.done(dly_done)
	);

	always_comb
	begin
		stat = 8'h00;
		stat[scc_pkg::ST_HANG_BIT] = (q.state == scc_pkg::SCC_HANG);
		stat[scc_pkg::ST_RUN_BIT] = q.run;
		stat[scc_pkg::ST_STOP_BIT] = (q.state == scc_pkg::SCC_STOP);
		stat[scc_pkg::ST_DEEP_BIT] = q.deep;
		stat[scc_pkg::ST_XTAL_OK_BIT] = xtal_stable;
		stat[scc_pkg::ST_WDT_RUN_BIT] = wdt_en && q.cmr[scc_pkg::CMR_LRC_EN_BIT];
		stat[scc_pkg::ST_BOOT_FAST_BIT] = q.boot_fast;
	end

	always_comb
	begin
		d = q;
		d.rsp.pready = 1'b0;
		d.rsp.pslverr = 1'b0;
		d.sys_rst = wdt_hit;
		d.lvr_rst = lvr_low_v && !q.aux[scc_pkg::AUX_LVR_DIS_BIT] && (q.state != scc_pkg::SCC_STOP);
		d.ext_rst = q.cmr[scc_pkg::CMR_EXT_RST_BIT] && port_a_bit5_is_input && !ext_reset_in_n;
		// The strap is caught in the first clocked cycle after reset release.
		if (!q.cap_done)
		begin
			d.boot_fast = boot_fast_cfg;
			d.cap_done = 1'b1;
		end
		case (q.state)
			scc_pkg::SCC_BOOT:
			begin
				if (q.cap_done && dly_done)
					d.state = scc_pkg::SCC_RUN;
			end
			scc_pkg::SCC_RUN:
			begin
				if (stop_deep_req)
				begin
					d.state = scc_pkg::SCC_STOP;
					d.deep = 1'b1;
				end
				else if (stop_light_req)
				begin
					d.state = scc_pkg::SCC_STOP;
					d.deep = 1'b0;
				end
			end
			scc_pkg::SCC_STOP:
			begin
				if (wake_evt)
					d.state = scc_pkg::SCC_WAKE;
			end
			scc_pkg::SCC_WAKE:
			begin
				d.deep = 1'b0;
				if (dly_done)
					d.state = scc_pkg::SCC_RUN;
			end
			scc_pkg::SCC_HANG:
			begin
				d.state = scc_pkg::SCC_HANG;
			end
			default:
			begin
				d.state = scc_pkg::SCC_BOOT;
			end
		endcase
		// A read answers one cycle into the access phase; pready stands for one cycle.
		if (acc)
		begin
			d.rsp.pready = 1'b1;
			d.rsp.prdata = 32'h00000000;
			case (a)
				scc_pkg::OFS_CLK_MODE: d.rsp.prdata[7:0] = q.cmr;
				scc_pkg::OFS_XTAL_CTRL: d.rsp.prdata[7:0] = q.xoc;
				scc_pkg::OFS_AUX_CTRL: d.rsp.prdata[7:0] = q.aux;
				scc_pkg::OFS_STATUS: d.rsp.prdata[7:0] = stat;
				scc_pkg::OFS_WDT_CLEAR: d.rsp.prdata[7:0] = 8'h00;
				default: d.rsp.pslverr = 1'b1;
			endcase
		end
		// No oscillator check guards the switch; a bad write stalls the core as silicon would.
		if (wr_cmr)
		begin
			d.cmr = w;
			d.src = nsrc;
			if (!osc_on(nsrc, w[scc_pkg::CMR_LRC_EN_BIT], q.xoc[scc_pkg::XOC_EN_BIT]))
				d.state = scc_pkg::SCC_HANG;
			if (nsrc == scc_pkg::SRC_XTAL && !xtal_stable)
				d.state = scc_pkg::SCC_HANG;
			if (nsrc != q.src && !osc_on(q.src, w[scc_pkg::CMR_LRC_EN_BIT], q.xoc[scc_pkg::XOC_EN_BIT]))
				d.state = scc_pkg::SCC_HANG;
		end
		if (wr && a == scc_pkg::OFS_XTAL_CTRL)
		begin
			d.xoc = w;
			if (q.src == scc_pkg::SRC_XTAL && !w[scc_pkg::XOC_EN_BIT])
				d.state = scc_pkg::SCC_HANG;
		end
		if (wr && a == scc_pkg::OFS_AUX_CTRL)
			d.aux = w;
		d.run = (d.state == scc_pkg::SCC_RUN);
		d.hang = (d.state == scc_pkg::SCC_HANG);
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
		begin
			q <= '0;
			q.state <= scc_pkg::SCC_BOOT;
			q.cmr <= scc_pkg::CMR_RST;
			q.xoc <= scc_pkg::XOC_RST;
			q.aux <= scc_pkg::AUX_RST;
			q.src <= scc_pkg::SRC_LOW;
		end
		else
			q <= d;
	end

	assign apb_rsp = q.rsp;
	assign cpu_run_q = q.run;
	assign cpu_hang_q = q.hang;
	assign sys_reset_q = q.sys_rst;
	assign lvr_reset_q = q.lvr_rst;
	assign ext_reset_q = q.ext_rst;
	assign clk_src_q = q.src;
	assign clk_div_code_q = q.cmr[scc_pkg::CMR_DIV_MSB:scc_pkg::CMR_DIV_LSB];
	assign low_rate_en_q = q.cmr[scc_pkg::CMR_LRC_EN_BIT];
	assign xtal_en_q = q.xoc[scc_pkg::XOC_EN_BIT];
	assign xtal_drive_q = q.xoc[scc_pkg::XOC_RANGE_MSB:scc_pkg::XOC_RANGE_LSB];
	// While the crystal runs its pads are forced to input, no pull-up, digital input off.
	assign xtal_pad_analog_q = q.xoc[scc_pkg::XOC_EN_BIT];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	property p_sel_and_stop_hangs;
		wr_cmr && nsrc != q.src && !osc_on(q.src, w[scc_pkg::CMR_LRC_EN_BIT], q.xoc[scc_pkg::XOC_EN_BIT])
		|=> q.state == scc_pkg::SCC_HANG;
	endproperty
	a_sel_and_stop_hangs: assert property (p_sel_and_stop_hangs) else $error("bad switch did not hang");

	property p_unsettled_xtal;
		wr_cmr && nsrc == scc_pkg::SRC_XTAL && !xtal_stable |=> cpu_hang_q && !cpu_run_q;
	endproperty
	a_unsettled_xtal: assert property (p_unsettled_xtal) else $error("early crystal select did not hang");

	property p_good_switch;
		wr_cmr && w == scc_pkg::CMR_HRC_DIV2_KEEP_LRC && q.src == scc_pkg::SRC_LOW && q.run
		|=> clk_src_q == scc_pkg::SRC_HIGH && low_rate_en_q && cpu_run_q;
	endproperty
	a_good_switch: assert property (p_good_switch) else $error("safe switch failed");

	property p_wdt_frozen;
		!low_rate_en_q && !wdt_clr && !wdt_hit |=> $stable(wdt_cnt);
	endproperty
	a_wdt_frozen: assert property (p_wdt_frozen) else $error("watchdog counted without its clock");

	property p_wdt_off;
		!wdt_en |=> wdt_cnt == 19'h00000;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog kept its count");

	property p_wdt_period;
		q.aux[1:0] == 2'h2 |-> wdt_lim == WDT_LIM2;
	endproperty
	a_wdt_period: assert property (p_wdt_period) else $error("watchdog period mismatch");

	property p_wdt_reset;
		wdt_cnt >= wdt_lim && wdt_en && !sys_reset_q |=> sys_reset_q ##1 !sys_reset_q && wdt_cnt == 19'h00000;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog timeout gave no reset pulse");

	property p_lvr_cause;
		lvr_reset_q |-> $past(lvr_low_v) && !$past(q.aux[scc_pkg::AUX_LVR_DIS_BIT]);
	endproperty
	a_lvr_cause: assert property (p_lvr_cause) else $error("low-voltage reset without cause");

	property p_lvr_stop;
		q.state == scc_pkg::SCC_STOP |=> !lvr_reset_q;
	endproperty
	a_lvr_stop: assert property (p_lvr_stop) else $error("low-voltage reset active in stop");

	property p_ext_rst;
		q.cmr[0] && port_a_bit5_is_input && !ext_reset_in_n |=> ext_reset_q;
	endproperty
	a_ext_rst: assert property (p_ext_rst) else $error("external reset not passed");

	property p_fast_wake;
		q.state == scc_pkg::SCC_WAKE && q.aux[scc_pkg::AUX_FAST_WAKE_BIT] |-> dly_lim == scc_pkg::DLY_FAST;
	endproperty
	a_fast_wake: assert property (p_fast_wake) else $error("fast wake delay wrong");

	property p_boot_slow;
		q.state == scc_pkg::SCC_BOOT && q.cap_done && !q.boot_fast |-> dly_lim == scc_pkg::DLY_SLOW;
	endproperty
	a_boot_slow: assert property (p_boot_slow) else $error("slow boot delay wrong");

	property p_boot_fast;
		q.state == scc_pkg::SCC_BOOT && q.cap_done && q.boot_fast |-> dly_lim == scc_pkg::DLY_FAST;
	endproperty
	a_boot_fast: assert property (p_boot_fast) else $error("fast boot delay wrong");

	property p_hang_sticky;
		cpu_hang_q |=> cpu_hang_q && !cpu_run_q;
	endproperty
	a_hang_sticky: assert property (p_hang_sticky) else $error("hung core resumed without reset");

	property p_ext_rst_off;
		!q.cmr[scc_pkg::CMR_EXT_RST_BIT] |=> !ext_reset_q;
	endproperty
	a_ext_rst_off: assert property (p_ext_rst_off) else $error("external reset passed while disabled");

	property p_wdt_off_quiet;
		!wdt_en |=> !sys_reset_q;
	endproperty
	a_wdt_off_quiet: assert property (p_wdt_off_quiet) else $error("disabled watchdog issued a reset");
endmodule : scc_top

//--- include/scc_pkg.sv
// Package for the system clock control block: offsets, fields, reset values and types.
package scc_pkg;
	localparam logic [7:0] OFS_CLK_MODE = 8'h00;
	localparam logic [7:0] OFS_XTAL_CTRL = 8'h04;
	localparam logic [7:0] OFS_AUX_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_WDT_CLEAR = 8'h10;
	localparam logic [7:0] CMR_RST = 8'he6;
	localparam logic [7:0] CMR_HRC_DIV2_KEEP_LRC = 8'h36;
	localparam int CMR_EXT_RST_BIT = 0;
	localparam int CMR_WDT_EN_BIT = 1;
	localparam int CMR_LRC_EN_BIT = 2;
	localparam int CMR_HRC_BIT = 4;
	localparam int CMR_DIV_LSB = 5;
	localparam int CMR_DIV_MSB = 7;
	localparam logic [2:0] CMR_XTAL_CODE = 3'h5;
	localparam logic [7:0] XOC_RST = 8'h00;
	localparam int XOC_EN_BIT = 7;
	localparam int XOC_RANGE_LSB = 5;
	localparam int XOC_RANGE_MSB = 6;
	localparam logic [7:0] AUX_RST = 8'h00;
	localparam int AUX_WDT_PER_LSB = 0;
	localparam int AUX_WDT_PER_MSB = 1;
	localparam int AUX_LVR_DIS_BIT = 2;
	localparam int AUX_FAST_WAKE_BIT = 5;
	localparam int ST_HANG_BIT = 0;
	localparam int ST_RUN_BIT = 1;
	localparam int ST_STOP_BIT = 2;
	localparam int ST_DEEP_BIT = 3;
	localparam int ST_XTAL_OK_BIT = 4;
	localparam int ST_WDT_RUN_BIT = 5;
	localparam int ST_BOOT_FAST_BIT = 6;
	localparam logic [1:0] SRC_LOW = 2'h0;
	localparam logic [1:0] SRC_HIGH = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam int WDT_W = 19;
	localparam logic [18:0] WDT_PER0 = 19'h02000;
	localparam logic [18:0] WDT_PER1 = 19'h04000;
	localparam logic [18:0] WDT_PER2 = 19'h10000;
	localparam logic [18:0] WDT_PER3 = 19'h40000;
	localparam int DLY_W = 12;
	localparam logic [11:0] DLY_SLOW = 12'hbb8;
	localparam logic [11:0] DLY_FAST = 12'h02d;

	typedef enum logic [4:0] {
		SCC_BOOT = 5'h01,
		SCC_RUN = 5'h02,
		SCC_STOP = 5'h04,
		SCC_WAKE = 5'h08,
		SCC_HANG = 5'h10
	} scc_state_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} scc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} scc_apb_rsp_t;

	typedef struct packed {
		scc_state_t state;
		logic [7:0] cmr;
		logic [7:0] xoc;
		logic [7:0] aux;
		logic [1:0] src;
		logic boot_fast;
		logic cap_done;
		logic deep;
		logic run;
		logic hang;
		logic sys_rst;
		logic lvr_rst;
		logic ext_rst;
		scc_apb_rsp_t rsp;
	} scc_regs_t;
endpackage : scc_pkg

//--- core/scc_tick_counter.sv
// Saturating tick counter with clear and a reached-limit flag.
`timescale 1ns/100ps
module scc_tick_counter #(
	parameter int W = 12
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic clr,
	input wire logic inc,
	input wire logic [W-1:0] limit,
	output logic [W-1:0] cnt,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} scc_cnt_regs_t;

	scc_cnt_regs_t q;
	scc_cnt_regs_t d;

	assign cnt = q.cnt;
	assign done = (q.cnt >= limit);

	// Counting stops at the limit so a long-held flag cannot wrap back to zero.
	always_comb
	begin
		d = q;
		if (clr)
			d.cnt = '0;
		else if (inc && !done)
			d.cnt = q.cnt + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clock)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end
endmodule : scc_tick_counter

//--- test/scc_top_bench.sv
// Self-checking bench for the system clock control block, driven over APB.
`timescale 1ns/100ps
module scc_top_bench;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	scc_pkg::scc_apb_req_t req = '0;
	scc_pkg::scc_apb_rsp_t rsp;
	logic tick = 1'b0;
	logic xst = 1'b0;
	logic pin_in = 1'b1;
	logic xrst_n = 1'b1;
	logic lowv = 1'b0;
	logic sl = 1'b0;
	logic sd = 1'b0;
	logic wake = 1'b0;
	logic strap = 1'b1;
	logic run, hang, srst, lvrr, xr, lrc, xen, pad;
	logic [1:0] src, drv;
	logic [2:0] div;
	logic [1:0] tdiv = 2'h0;
	logic [31:0] rd;
	logic er;
	int err_count = 0;
	int n_checks = 0;
	int pulses = 0;
	int t, i, p0;

	always #50 clock = ~clock;

	// One low-rate tick every four system clocks keeps the counts short but still multi-cycle.
	always @(posedge clock)
	begin
		tdiv <= tdiv + 2'h1;
		tick <= (tdiv == 2'h3);
		pulses <= pulses + int'(srst === 1'b1);
	end

	scc_top #(.WDT_LIM0(19'h00008), .WDT_LIM1(19'h00010), .WDT_LIM2(19'h00020), .WDT_LIM3(19'h00040)) u_scc_top (
		.clock(clock), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .low_rate_tick(tick),
		.xtal_stable(xst), .boot_fast_cfg(strap), .port_a_bit5_is_input(pin_in), .ext_reset_in_n(xrst_n),
		.lvr_low_v(lowv), .stop_light_req(sl), .stop_deep_req(sd), .wake_evt(wake),
		.cpu_run_q(run), .cpu_hang_q(hang), .sys_reset_q(srst), .lvr_reset_q(lvrr), .ext_reset_q(xr),
		.clk_src_q(src), .clk_div_code_q(div), .low_rate_en_q(lrc), .xtal_en_q(xen), .xtal_drive_q(drv),
		.xtal_pad_analog_q(pad)
	);

	task results();
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Request is held until pready is seen high at a rising edge, then released.
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		do
			@(posedge clock);
		while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task nap(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask : nap

	task rst();
		@(posedge clock);
		rstn <= 1'b0;
		repeat (6) @(posedge clock);
		rstn <= 1'b1;
	endtask : rst

	task wdog(input logic [1:0] p, input int lim);
		apb(scc_pkg::OFS_AUX_CTRL, 1'b1, {30'h0, p});
		apb(scc_pkg::OFS_WDT_CLEAR, 1'b1, 32'h0);
		t = 0;
		while (srst !== 1'b1 && t < 400)
		begin
			@(posedge clock);
			t++;
		end
		chk("wdt_period", 32'h1, 32'(t >= lim * 4 - 4 && t <= lim * 4 + 16));
	endtask : wdog

	initial
	begin
		repeat (20000) @(posedge clock);
		err_count++;
		results();
	end

	initial
	begin
		rst();
		t = 0;
		while (run !== 1'b1 && t < 400)
		begin
			@(posedge clock);
			t++;
		end
		chk("boot_time", 32'h1, 32'(t >= 176 && t <= 200));
		chk("wdt_on_reset", 32'h1, 32'(pulses > 0));
		apb(scc_pkg::OFS_CLK_MODE, 1'b0, 32'h0);
		chk("clock_mode", 32'h000000e6, rd);
		apb(8'h14, 1'b0, 32'h0);
		chk("unmapped_err", 32'h1, 32'(er));
		chk("unmapped_data", 32'h0, rd);
		for (i = 0; i < 4; i++)
			wdog(i[1:0], 8 << i);
		// Watchdog off from here to the 32'h36 write so that its pulses cannot disturb the counts in between.
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'he5);
		p0 = pulses;
		@(posedge clock);
		xrst_n <= 1'b0;
		nap(2);
		chk("ext_reset_on", 32'h1, 32'(xr));
		@(posedge clock);
		pin_in <= 1'b0;
		nap(2);
		chk("ext_reset_pin_out", 32'h0, 32'(xr));
		@(posedge clock);
		pin_in <= 1'b1;
		xrst_n <= 1'b1;
		lowv <= 1'b1;
		nap(2);
		chk("lvr_on", 32'h1, 32'(lvrr));
		apb(scc_pkg::OFS_AUX_CTRL, 1'b1, 32'h04);
		nap(2);
		chk("lvr_disabled", 32'h0, 32'(lvrr));
		apb(scc_pkg::OFS_AUX_CTRL, 1'b1, 32'h20);
		for (i = 0; i < 2; i++)
		begin
			@(posedge clock);
			sl <= (i == 0);
			sd <= (i == 1);
			@(posedge clock);
			sl <= 1'b0;
			sd <= 1'b0;
			nap(2);
			chk("stop_run", 32'h0, 32'(run));
			chk("stop_lvr", 32'h0, 32'(lvrr));
			@(posedge clock);
			wake <= 1'b1;
			@(posedge clock);
			wake <= 1'b0;
			nap(160);
			chk("wake_early", 32'h0, 32'(run));
			nap(40);
			chk("wake_done", 32'h1, 32'(run));
		end
		@(posedge clock);
		lowv <= 1'b0;
		chk("wdt_disabled", p0, pulses);
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'h36);
		nap(2);
		chk("src_high", 32'(scc_pkg::SRC_HIGH), 32'(src));
		chk("div_code", 32'h1, 32'(div));
		chk("lrc_kept", 32'h1, 32'(lrc));
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'h32);
		p0 = pulses;
		nap(400);
		chk("lrc_stopped", 32'h0, 32'(lrc));
		chk("no_hang_two_step", 32'h0, 32'(hang));
		chk("wdt_no_lrc", p0, pulses);
		for (i = 1; i < 4; i++)
		begin
			apb(scc_pkg::OFS_XTAL_CTRL, 1'b1, {24'h0, 1'b1, i[1:0], 5'h0});
			nap(2);
			chk("xtal_drive", 32'(i), 32'(drv));
			chk("xtal_en", 32'h1, 32'(xen));
			chk("xtal_pad", 32'h1, 32'(pad));
		end
		rst();
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'h50);
		nap(2);
		chk("hang_one_write", 32'h1, 32'(hang));
		rst();
		apb(scc_pkg::OFS_XTAL_CTRL, 1'b1, 32'he0);
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'ha6);
		nap(2);
		chk("hang_xtal_early", 32'h1, 32'(hang));
		rst();
		xst <= 1'b1;
		apb(scc_pkg::OFS_XTAL_CTRL, 1'b1, 32'he0);
		apb(scc_pkg::OFS_CLK_MODE, 1'b1, 32'ha6);
		nap(2);
		chk("src_xtal", 32'(scc_pkg::SRC_XTAL), 32'(src));
		chk("no_hang_settled", 32'h0, 32'(hang));
		// The slow strap is tried last because its boot takes far longer than everything else.
		rst();
		strap <= 1'b0;
		t = 0;
		while (run !== 1'b1 && t < 13000)
		begin
			@(posedge clock);
			t++;
		end
		i = 4 * int'(scc_pkg::DLY_SLOW);
		chk("boot_slow", 32'h1, 32'(t >= i - 4 && t <= i + 20));
		apb(scc_pkg::OFS_STATUS, 1'b0, 32'h0);
		chk("status", 32'h00000032, rd);
		results();
	end
endmodule : scc_top_bench
